// File: core/ctbd_regs.svh
`ifndef CTBD_REGS_SVH
`define CTBD_REGS_SVH

`define CTBD_LATENCY 2
`define CTBD_MIXED_TAG_BIT 127
`define CTBD_MODE3_LO 125
`define CTBD_MODE3_ALPHA 3'h3
`define CTBD_ISEL_BIT 124
`define CTBD_C0_LO 64
`define CTBD_C1_LO 79
`define CTBD_C2_LO 94
`define CTBD_C3_LO 109
`define CTBD_A0_LO 109
`define CTBD_A1_LO 114
`define CTBD_A2_LO 119
`define CTBD_G1_LSB_BIT 125
`define CTBD_G3_LSB_BIT 126
`define CTBD_HALF_W 64
`define CTBD_E1_LO 16
`define CTBD_MAP_LO 32
`define CTBD_IALPHA_MAP_LO 16
`define CTBD_OPAQUE 8'hff
`define CTBD_TILE_SIDE 4

`endif

// File: core/ctbd_pkg.sv
package ctbd_pkg;

  typedef enum logic [1:0] {
    CTBD_FAM_TAGGED = 2'h0,
    CTBD_FAM_PAIR64 = 2'h1,
    CTBD_FAM_PAIR_INTERP = 2'h3,
    CTBD_FAM_PAIR_EXPL = 2'h2
  } ctbd_fam_e;

  typedef struct packed {
    ctbd_fam_e fam;
    logic [127:0] block;
    logic [1:0] row;
    logic [2:0] col;
    logic [2:0] rows;
    logic [3:0] cols;
  } ctbd_req_s;

  typedef struct packed {
    logic [31:0] argb;
    logic pad;
    logic unsupported;
  } ctbd_rsp_s;

endpackage

// File: core/ctbd_mix.sv
`timescale 1ns/1ps
`include "ctbd_regs.svh"

module ctbd_mix (
  input wire logic [7:0] a,
  input wire logic [7:0] b,
  output logic [7:0] near_a,
  output logic [7:0] near_b,
  output logic [7:0] near_a_rnd,
  output logic [7:0] near_b_rnd,
  output logic [7:0] mid
);

  logic [9:0] sum_a;
  logic [9:0] sum_b;
  logic [8:0] sum_h;

  // weighted sums per channel, truncating division, plus rounded thirds for the rnd outputs
  assign sum_a = {1'b0, a, 1'b0} + {2'h0, b};
  assign sum_b = {2'h0, a} + {1'b0, b, 1'b0};
  assign sum_h = {1'b0, a} + {1'b0, b};
  assign near_a = 8'(sum_a / 10'h3);
  assign near_b = 8'(sum_b / 10'h3);
  assign near_a_rnd = 8'((sum_a + 10'h1) / 10'h3);
  assign near_b_rnd = 8'((sum_b + 10'h1) / 10'h3);
  assign mid = sum_h[8:1];

endmodule

// File: core/ctbd_decoder.sv
`timescale 1ns/1ps
`include "ctbd_regs.svh"

module ctbd_decoder #(
  parameter int ARGB_W = 32,
  parameter int BLOCK_W = 128
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic in_valid,
  input wire ctbd_pkg::ctbd_req_s in_req,
  output logic in_ready,
  output logic out_valid,
  output ctbd_pkg::ctbd_rsp_s out_rsp
);

  // ---------------------------------------------------------------
  // elaboration checks
  // ---------------------------------------------------------------
  generate
    if (ARGB_W != 32) begin : g_bad_argb
      $error("ctbd_decoder: only 32-bit ARGB output is served");
    end
    if (BLOCK_W != 128) begin : g_bad_block
      $error("ctbd_decoder: only 128-bit block input is served");
    end
  endgenerate

  // ---------------------------------------------------------------
  // widening helpers
  // ---------------------------------------------------------------
  function automatic logic [7:0] wid5(input logic [4:0] v);
    wid5 = {v, v[4:2]};
  endfunction

  function automatic logic [7:0] wid6(input logic [5:0] v);
    wid6 = {v, v[5:4]};
  endfunction

  function automatic logic [23:0] rgb555(input logic [14:0] v);
    rgb555 = {wid5(v[14:10]), wid5(v[9:5]), wid5(v[4:0])};
  endfunction

  function automatic logic [23:0] rgb565(input logic [15:0] v);
    rgb565 = {wid5(v[15:11]), wid6(v[10:5]), wid5(v[4:0])};
  endfunction

  // eight-value or six-value alpha, chosen by the endpoint compare
  function automatic logic [7:0] alpha_interp(
    input logic [7:0] a0,
    input logic [7:0] a1,
    input logic [2:0] k
  );
    logic [10:0] w0;
    logic [10:0] w1;
    logic [10:0] s;
    begin
      w0 = 11'h0;
      w1 = {8'h0, k} - 11'h1;
      s = 11'h0;
      alpha_interp = 8'h00;
      if (k == 3'h0) begin
        alpha_interp = a0;
      end else if (k == 3'h1) begin
        alpha_interp = a1;
      end else if (a0 > a1) begin
        w0 = 11'h8 - {8'h0, k};
        s = w0 * {3'h0, a0} + w1 * {3'h0, a1};
        alpha_interp = 8'(s / 11'h7);
      end else if (k == 3'h6) begin
        alpha_interp = 8'h00;
      end else if (k == 3'h7) begin
        alpha_interp = `CTBD_OPAQUE;
      end else begin
        w0 = 11'h6 - {8'h0, k};
        s = w0 * {3'h0, a0} + w1 * {3'h0, a1};
        alpha_interp = 8'(s / 11'h5);
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // request stage
  // ---------------------------------------------------------------
  logic s1_valid_reg;
  ctbd_pkg::ctbd_req_s s1_req_reg;
  logic in_ready_reg;
  logic take;

  assign take = in_valid && in_ready_reg;
  assign in_ready = in_ready_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      in_ready_reg <= 1'b0;
    end else if (ce) begin
      in_ready_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_valid_reg <= 1'b0;
    end else if (ce) begin
      s1_valid_reg <= take;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      s1_req_reg <= '0;
    end else if (ce && take) begin
      s1_req_reg <= in_req;
    end
  end

  // ---------------------------------------------------------------
  // block fields
  // ---------------------------------------------------------------
  logic [127:0] blk;
  ctbd_pkg::ctbd_fam_e fam;
  logic is_tagged;
  logic is_mixed;
  logic mixed_alpha;
  logic is_alpha3;
  logic isel;
  logic [4:0] tex32;
  logic [3:0] tex16;
  logic half_hi;
  logic [1:0] code32;

  assign blk = s1_req_reg.block;
  assign fam = s1_req_reg.fam;
  assign is_tagged = (fam == ctbd_pkg::CTBD_FAM_TAGGED);
  assign is_mixed = is_tagged && blk[`CTBD_MIXED_TAG_BIT];
  assign mixed_alpha = blk[`CTBD_ISEL_BIT];
  assign is_alpha3 = is_tagged
    && (blk[`CTBD_MODE3_LO +: 3] == `CTBD_MODE3_ALPHA);
  assign isel = blk[`CTBD_ISEL_BIT];

  // texel number: columns 4-7 form the upper half of a 32-texel block
  assign tex32 = {s1_req_reg.col[2], s1_req_reg.row, s1_req_reg.col[1:0]};
  assign tex16 = {s1_req_reg.row, s1_req_reg.col[1:0]};
  assign half_hi = tex32[4];
  assign code32 = blk[{tex32, 1'b0} +: 2];

  // ---------------------------------------------------------------
  // two-pair block colours (alpha flag set)
  // ---------------------------------------------------------------
  logic [23:0] mx_c0;
  logic [23:0] mx_c1;
  logic [23:0] mx_c2;
  logic [23:0] mx_c3;
  logic [14:0] raw1;
  logic [14:0] raw3;

  assign raw1 = blk[`CTBD_C1_LO +: 15];
  assign raw3 = blk[`CTBD_C3_LO +: 15];
  assign mx_c0 = rgb555(blk[`CTBD_C0_LO +: 15]);
  assign mx_c2 = rgb555(blk[`CTBD_C2_LO +: 15]);
  assign mx_c1 = rgb565({raw1[14:5], blk[`CTBD_G1_LSB_BIT], raw1[4:0]});
  assign mx_c3 = rgb565({raw3[14:5], blk[`CTBD_G3_LSB_BIT], raw3[4:0]});

  // ---------------------------------------------------------------
  // three-colour alpha block colours
  // ---------------------------------------------------------------
  logic [31:0] al_c0;
  logic [31:0] al_c1;
  logic [31:0] al_c2;

  assign al_c0 = {wid5(blk[`CTBD_A0_LO +: 5]), mx_c0};
  assign al_c1 = {wid5(blk[`CTBD_A1_LO +: 5]), rgb555(raw1)};
  assign al_c2 = {wid5(blk[`CTBD_A2_LO +: 5]), mx_c2};

  // ---------------------------------------------------------------
  // endpoint family fields
  // ---------------------------------------------------------------
  logic [63:0] col_half;
  logic [63:0] alp_half;
  logic [15:0] ep0;
  logic [15:0] ep1;
  logic [31:0] ep_map;
  logic [1:0] code16;
  logic four_col;
  logic [7:0] half_alpha;
  logic [3:0] expl_nib;
  logic [5:0] ialpha_pos;

  // 16-byte blocks carry alpha in the low 8 bytes, colour in the high 8
  assign col_half = (fam == ctbd_pkg::CTBD_FAM_PAIR64)
    ? blk[63:0] : blk[127:64];
  assign alp_half = blk[63:0];
  assign ep0 = col_half[15:0];
  assign ep1 = col_half[`CTBD_E1_LO +: 16];
  assign ep_map = col_half[`CTBD_MAP_LO +: 32];
  assign code16 = ep_map[{tex16, 1'b0} +: 2];

  // per-block opaque test; colour half of 16-byte blocks is always four-colour
  assign four_col = (fam != ctbd_pkg::CTBD_FAM_PAIR64) || (ep0 > ep1);

  assign expl_nib = alp_half[{tex16, 2'b00} +: 4];
  assign ialpha_pos = 6'(`CTBD_IALPHA_MAP_LO + 3 * tex16);

  always_comb begin
    half_alpha = `CTBD_OPAQUE;
    if (fam == ctbd_pkg::CTBD_FAM_PAIR_EXPL) begin
      half_alpha = {expl_nib, expl_nib};
    end else if (fam == ctbd_pkg::CTBD_FAM_PAIR_INTERP) begin
      half_alpha = alpha_interp(alp_half[7:0], alp_half[15:8],
        alp_half[ialpha_pos +: 3]);
    end
  end

  // ---------------------------------------------------------------
  // endpoint pair selection and per-channel mixing
  // ---------------------------------------------------------------
  logic [31:0] pa;
  logic [31:0] pb;
  logic [31:0] m_na;
  logic [31:0] m_nb;
  logic [31:0] m_nar;
  logic [31:0] m_nbr;
  logic [31:0] m_mid;

  always_comb begin
    pa = {`CTBD_OPAQUE, rgb565(ep0)};
    pb = {`CTBD_OPAQUE, rgb565(ep1)};
    if (is_mixed) begin
      pa = {`CTBD_OPAQUE, half_hi ? mx_c2 : mx_c0};
      pb = {`CTBD_OPAQUE, half_hi ? mx_c3 : mx_c1};
    end else if (is_alpha3) begin
      pa = half_hi ? al_c2 : al_c0;
      pb = al_c1;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < 4; ch++) begin : g_chan
      ctbd_mix u_mix (
        .a(pa[ch*8 +: 8]),
        .b(pb[ch*8 +: 8]),
        .near_a(m_na[ch*8 +: 8]),
        .near_b(m_nb[ch*8 +: 8]),
        .near_a_rnd(m_nar[ch*8 +: 8]),
        .near_b_rnd(m_nbr[ch*8 +: 8]),
        .mid(m_mid[ch*8 +: 8])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // texel selection
  // ---------------------------------------------------------------
  logic pad_hit;
  ctbd_pkg::ctbd_rsp_s rsp_next;
  logic [31:0] ep_argb;

  // texels beyond the real surface edge are not decoded
  assign pad_hit = ({1'b0, s1_req_reg.col} >= s1_req_reg.cols)
    || ({1'b0, s1_req_reg.row} >= s1_req_reg.rows)
    || (!is_tagged && s1_req_reg.col[2]);

  always_comb begin
    ep_argb = 32'h0;
    unique case (code16)
      2'h0: ep_argb = pa;
      2'h1: ep_argb = pb;
      2'h2: ep_argb = four_col ? m_na : m_mid;
      2'h3: ep_argb = four_col ? m_nb : 32'h0;
    endcase
    if (fam != ctbd_pkg::CTBD_FAM_PAIR64) begin
      ep_argb[31:24] = half_alpha;
    end
  end

  always_comb begin
    rsp_next = '0;
    if (pad_hit) begin
      rsp_next.pad = 1'b1;
    end else if (is_mixed) begin
      if (mixed_alpha) begin
        unique case (code32)
          2'h0: rsp_next.argb = pa;
          2'h1: rsp_next.argb = {`CTBD_OPAQUE, m_mid[23:0]};
          2'h2: rsp_next.argb = pb;
          2'h3: rsp_next.argb = 32'h0;
        endcase
      end else begin
        rsp_next.unsupported = 1'b1;
      end
    end else if (is_alpha3) begin
      if (!isel) begin
        unique case (code32)
          2'h0: rsp_next.argb = al_c0;
          2'h1: rsp_next.argb = al_c1;
          2'h2: rsp_next.argb = al_c2;
          2'h3: rsp_next.argb = 32'h0;
        endcase
      end else begin
        unique case (code32)
          2'h0: rsp_next.argb = pa;
          2'h1: rsp_next.argb = m_nar;
          2'h2: rsp_next.argb = m_nbr;
          2'h3: rsp_next.argb = pb;
        endcase
      end
    end else if (is_tagged) begin
      rsp_next.unsupported = 1'b1;
    end else begin
      rsp_next.argb = ep_argb;
    end
  end

  // ---------------------------------------------------------------
  // output stage
  // ---------------------------------------------------------------
  logic out_valid_reg;
  ctbd_pkg::ctbd_rsp_s out_rsp_reg;

  always_ff @(posedge clock) begin
    if (srst) begin
      out_valid_reg <= 1'b0;
    end else if (ce) begin
      out_valid_reg <= s1_valid_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      out_rsp_reg <= '0;
    end else if (ce && s1_valid_reg) begin
      out_rsp_reg <= rsp_next;
    end
  end

  assign out_valid = out_valid_reg;
  assign out_rsp = out_rsp_reg;

endmodule

// File: tb/ctbd_decoder_monitor.sv
`timescale 1ns/1ps
module ctbd_decoder_monitor (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic in_valid,
  input wire ctbd_pkg::ctbd_req_s in_req,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire ctbd_pkg::ctbd_rsp_s out_rsp
);
  logic [1:0] s1_reg;
  logic [1:0] s2_reg;
  logic pad_cause;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);
  assign pad_cause = {1'b0, in_req.col} >= in_req.cols || {1'b0, in_req.row} >= in_req.rows
    || (in_req.fam != ctbd_pkg::CTBD_FAM_TAGGED && in_req.col[2]);
  // ------
  // take and padding shadow, two enabled stages
  // ------
  always_ff @(posedge clock) begin
    if (srst) begin
      s1_reg <= 2'h0;
      s2_reg <= 2'h0;
    end else if (ce) begin
      s1_reg <= {in_valid && in_ready, pad_cause};
      s2_reg <= s1_reg;
    end
  end
  a_answer_latency: assert property (out_valid == s2_reg[1])
    else $error("answer strobe off its slot");
  a_ready_rise: assert property ($past(srst) && ce |=> in_ready)
    else $error("ready late after reset");
  a_ready_hold: assert property (in_ready |=> in_ready)
    else $error("ready dropped");
  a_rsp_hold: assert property (!$stable(out_rsp) |-> out_valid)
    else $error("texel changed without strobe");
  a_one_pulse: assert property (out_valid && ce && !s1_reg[1] |=> !out_valid)
    else $error("strobe longer than one cycle");
  a_pad_zero: assert property (out_valid && out_rsp.pad |-> out_rsp.argb == 32'h0)
    else $error("padding texel not zero");
  a_pad_cause: assert property (out_valid |-> out_rsp.pad == s2_reg[0])
    else $error("padding flag wrong");
  a_unsup_zero: assert property (out_valid && out_rsp.unsupported |-> out_rsp.argb == 32'h0)
    else $error("unsupported texel not zero");
endmodule

// File: tb/ctbd_sampler_model.sv
`timescale 1ns/1ps
module ctbd_sampler_model (
  input wire logic clock,
  input wire logic ce,
  input wire logic out_valid,
  input wire ctbd_pkg::ctbd_rsp_s out_rsp
);
  ctbd_pkg::ctbd_rsp_s got[$];
  // each texel is consumed once, at the enabled edge that closes its cycle
  always @(posedge clock) begin
    if (out_valid && ce) begin
      got.push_back(out_rsp);
    end
  end
endmodule

// File: tb/tb_ctbd_decoder.sv
`timescale 1ns/1ps
module tb_ctbd_decoder;
  logic clock, srst, ce, in_valid, in_ready, out_valid, took;
  ctbd_pkg::ctbd_req_s in_req;
  ctbd_pkg::ctbd_rsp_s out_rsp;
  ctbd_pkg::ctbd_rsp_s expq[$];
  int n_fail, cmp_count, seed;
  ctbd_decoder dut (.clock(clock), .srst(srst), .ce(ce), .in_valid(in_valid), .in_req(in_req),
    .in_ready(in_ready), .out_valid(out_valid), .out_rsp(out_rsp));
  ctbd_sampler_model snk (.clock(clock), .ce(ce), .out_valid(out_valid), .out_rsp(out_rsp));
  // ------
  // reference model
  // ------
  function automatic logic [7:0] x5(logic [4:0] v);
    return {v, v[4:2]};
  endfunction
  function automatic logic [31:0] c565(logic [15:0] w);
    return {8'hff, x5(w[15:11]), w[10:5], w[10:9], x5(w[4:0])};
  endfunction
  function automatic logic [31:0] mix(logic [31:0] a, logic [31:0] b, int wa, int wb,
    int d, int rn);
    logic [31:0] o;
    for (int i = 0; i < 32; i += 8) begin
      o[i+:8] = 8'((wa * a[i+:8] + wb * b[i+:8] + rn) / d);
    end
    return o;
  endfunction
  function automatic ctbd_pkg::ctbd_rsp_s model(ctbd_pkg::ctbd_req_s q);
    ctbd_pkg::ctbd_rsp_s r;
    logic [127:0] b;
    logic [31:0] c[4];
    logic [15:0] w0, w1;
    int t, k, hi, s, a0, a1, o;
    r = '0;
    b = q.block;
    hi = q.col[2];
    if ({1'b0, q.col} >= q.cols || {1'b0, q.row} >= q.rows ||
        (q.fam != ctbd_pkg::CTBD_FAM_TAGGED && q.col[2])) begin
      r.pad = 1'b1;
      return r;
    end
    if (q.fam == ctbd_pkg::CTBD_FAM_TAGGED) begin
      t = {q.col[2], q.row, q.col[1:0]};
      k = b[2*t+:2];
      for (int i = 0; i < 4; i++) begin
        c[i] = {8'hff, x5(b[74+15*i+:5]), x5(b[69+15*i+:5]), x5(b[64+15*i+:5])};
        if (i < 3 && b[127:125] == 3'h3) c[i][31:24] = x5(b[109+5*i+:5]);
        if (b[127] && i[0]) c[i][15:8] = {b[69+15*i+:5], b[125+i/2], b[72+15*i+:2]};
      end
      if (b[127:125] == 3'h3 && !b[124]) r.argb = k == 3 ? 32'h0 : c[k];
      else if (b[127:125] == 3'h3) r.argb = k == 0 ? c[2*hi] : k == 3 ? c[1] :
        mix(c[2*hi], c[1], 3 - k, k, 3, 1);
      else if (b[127] && b[124]) r.argb = k == 3 ? 32'h0 : k == 1 ?
        mix(c[2*hi], c[2*hi+1], 1, 1, 2, 0) : c[2*hi+k/2];
      else r.unsupported = 1'b1;
    end else begin
      o = q.fam == ctbd_pkg::CTBD_FAM_PAIR64 ? 0 : 64;
      w0 = b[o+:16];
      w1 = b[o+16+:16];
      t = 4 * q.row + q.col;
      k = b[o+32+2*t+:2];
      c[0] = c565(w0);
      c[1] = c565(w1);
      if (w0 > w1 || o == 64) r.argb = k < 2 ? c[k] : mix(c[0], c[1], 4 - k, k - 1, 3, 0);
      else r.argb = k < 2 ? c[k] : k == 2 ? mix(c[0], c[1], 1, 1, 2, 0) : 32'h0;
      a0 = b[7:0];
      a1 = b[15:8];
      s = b[16+3*t+:3];
      if (q.fam == ctbd_pkg::CTBD_FAM_PAIR_EXPL) r.argb[31:24] = {2{b[4*t+:4]}};
      if (q.fam == ctbd_pkg::CTBD_FAM_PAIR_INTERP) r.argb[31:24] = 8'(s < 2 ? (s ? a1 : a0) :
        a0 > a1 ? ((8 - s) * a0 + (s - 1) * a1) / 7 : s == 6 ? 0 : s == 7 ? 255 :
        ((6 - s) * a0 + (s - 1) * a1) / 5);
    end
    return r;
  endfunction
  // ------
  // checks and report
  // ------
  task automatic chk_rsp(ctbd_pkg::ctbd_rsp_s g, ctbd_pkg::ctbd_rsp_s e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_bit(logic g, logic e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge clock) begin
    while (snk.got.size() > 0) begin
      chk_bit(expq.size() > 0, 1'b1);
      if (expq.size() > 0) chk_rsp(snk.got.pop_front(), expq.pop_front());
      else snk.got.delete(0);
    end
  end
  // ------
  // stimulus
  // ------
  task automatic do_reset(int n);
    srst = 1'b1;
    repeat (n) @(negedge clock);
    chk_bit(in_ready | out_valid, 1'b0);
    chk_rsp(out_rsp, '0);
    srst = 1'b0;
    $display("test reset done");
  endtask
  task automatic stream(int n);
    ctbd_pkg::ctbd_req_s q;
    int r, fam, i;
    i = 0;
    fam = 0;
    while (i < n) begin
      @(negedge clock);
      r = $random(seed);
      if (!in_valid || took) begin
        if (i % 16 == 0) fam = r[5:4];
        q.fam = ctbd_pkg::ctbd_fam_e'(fam);
        q.block = {$random(seed), $random(seed), $random(seed), $random(seed)};
        q.row = r[7:6];
        q.col = r[10:8];
        q.rows = 3'(r[12:11] + 1);
        q.cols = 4'(r[15:13] + 1);
        case (r[17:16])
          2'h0: q.block[127:125] = 3'h3;
          2'h1: {q.block[127], q.block[124]} = 2'h3;
          2'h2: {q.block[127], q.block[124]} = 2'h2;
          default: ;
        endcase
        if (r[19:18] == 2'h0) q.block[31:16] = q.block[15:0];
        in_req = q;
        in_valid = in_ready && r[21:20] != 2'h0;
      end
      ce = r[3:0] != 4'h0;
      took = in_valid && ce;
      if (took) begin
        expq.push_back(model(in_req));
        i++;
      end
    end
  endtask
  task automatic drain(string name);
    // last request is taken at the coming edge; withdraw it after that edge, before it repeats
    @(negedge clock);
    ce = 1'b1;
    in_valid = 1'b0;
    took = 1'b0;
    for (int w = 0; w < 50 && expq.size() > 0; w++) @(negedge clock);
    chk_bit(expq.size() == 0, 1'b1);
    $display("test %s done", name);
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #400000;
    n_fail++;
    summarize;
  end
  initial begin
    seed = 40;
    n_fail = 0;
    cmp_count = 0;
    took = 1'b0;
    ce = 1'b1;
    in_valid = 1'b0;
    in_req = '0;
    do_reset(4);
    stream(400);
    drain("stream");
    do_reset(2);
    stream(200);
    drain("after reset");
    summarize;
  end
endmodule
bind ctbd_decoder ctbd_decoder_monitor mon (.clock(clock), .srst(srst), .ce(ce),
  .in_valid(in_valid), .in_req(in_req), .in_ready(in_ready), .out_valid(out_valid),
  .out_rsp(out_rsp));
